// ---- bench/softstart_and_power_good_sequencer_bench.sv ----
`timescale 1ns/1ns

module softstart_and_power_good_sequencer_bench;
    localparam [31:0] C = 32'h0000000a;
    reg          clk, nrst, en_req, slow, precise, fault;
    reg  [15:0]  ofs;
    reg  [1:0]   lvl;
    reg  [4:0]   code, wr_v;
    reg  [7:0]   wd;
    reg  [11:0]  vnom;
    wire         en_pin, pg, ready;
    wire [11:0]  vout, vref;
    wire [1:0]   input_undervoltage_lockout;
    wire [7:0]   dly_o, ramp_o;
    wire [2:0]   st;
    integer      n_fail, check_count, i, k, t, e0, e1, e2;
    integer      rtab [0:9];
    integer      ov [0:5];

    sspg_sys_model #(.VW(12)) u_sys (.clk(clk), .en_req(en_req), .slow(slow), .ofs(ofs),
        .vref(vref), .en_pin(en_pin), .vout(vout));
    sspg_top #(.CYC_PER_MS(C), .VW(12)) u_dut (.CORE_CLK(clk), .NRST(nrst), .EN_PIN(en_pin),
        .STRAP_LEVEL(lvl), .STRAP_CODE(code), .RELOAD(wr_v[3]), .DLY_WR(wr_v[0]),
        .DLY_DATA(wd), .RAMP_WR(wr_v[1]), .RAMP_DATA(wd), .PG_DLY_WR(wr_v[2]),
        .PG_DLY_DATA(wd), .WIN_WR(wr_v[4]), .WIN_HI_DATA(wd), .WIN_LO_DATA(wd - 8'h05),
        .PRECISE_EN(precise), .VNOM(vnom), .VOUT_MEAS(vout), .FAULT(fault),
        .VREF_OUT(vref), .OUTPUT_GOOD_FLAG(pg), .INPUT_UNDERVOLTAGE_LOCKOUT_SEL(input_undervoltage_lockout), .DLY_MS_OUT(dly_o),
        .RAMP_MS_OUT(ramp_o), .READY(ready), .SEQ_STATE(st));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task report_and_stop;
        begin
            $display("checks %0d errors %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // range compare, lo equal hi for exact values
    task chk(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s exp %0d..%0d seen %0d", nm, lo, hi, g);
            end
        end
    endtask

    // bounded wait on state (sel 0) or flag (sel 1), n counts cycles
    task wait_for(input integer sel, input [31:0] v, input integer lim, output integer n);
        begin
            n = 0;
            while ((sel == 0 ? {29'h0, st} : {31'h0, pg}) !== v && n < lim) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= lim) begin
                chk("wait", v, v, 32'hffffffff);
                report_and_stop;
            end
        end
    endtask

    // 0 delay, 1 ramp, 2 good delay, 3 reload, 4 window
    task wr(input integer w, input [7:0] d);
        begin
            @(posedge clk);
            wd <= d;
            wr_v <= 5'h01 << w;
            @(posedge clk);
            wr_v <= 5'h00;
            @(posedge clk);
            #1;
        end
    endtask

    // expected strap decode
    task exp_strap(input integer l, input integer c, output integer d, output integer r,
                   output integer u);
        begin
            u = (l < 3 || c >= 30) ? 2 : (c < 6) ? 0 : (c < 18) ? 1 : 2;
            d = (l < 3) ? ((l == 0) ? 2 : (l == 1) ? 5 : 10) : (c >= 30) ? 5 : 5 << (c % 3);
            r = (l < 3 || c >= 30) ? d : rtab[c / 3];
        end
    endtask

    initial begin
        k = $urandom(32'h8f98560f);
        rtab = '{5, 10, 2, 5, 10, 20, 2, 5, 10, 20};
        ov = '{150, 151, -100, -101, 200, -160};
        n_fail = 0;
        check_count = 0;
        {nrst, en_req, slow, precise, fault, ofs, code, wr_v, wd} = 0;
        lvl = 2'h1;
        vnom = 12'h3e8;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("state", 0, 0, st);
        chk("ready", 0, 0, ready);
        chk("input_undervoltage_lockout", 2, 2, input_undervoltage_lockout);
        chk("flag", 0, 0, pg);
        wait_for(0, 1, 100, t);
        chk("ready", 1, 1, ready);
        // every strap level and resistor codes 0 to 30, relatched by reload
        for (i = 0; i < 34; i = i + 1) begin
            @(posedge clk);
            lvl <= (i < 3) ? i : 3;
            code <= (i < 3) ? 0 : i - 3;
            wr(3, 0);
            wait_for(0, 1, 100, t);
            @(posedge clk); // status lags the strap latch by one cycle
            #1;
            exp_strap(lvl, code, e0, e1, e2);
            chk("dly", e0, e0, dly_o);
            chk("ramp", e1, e1, ramp_o);
            chk("input_undervoltage_lockout", e2, e2, input_undervoltage_lockout);
        end
        // later strap change and writes during init are ignored
        @(posedge clk);
        lvl <= 2'h0;
        repeat (10) @(posedge clk);
        chk("dly hold", 5, 5, dly_o);
        wr(3, 0);
        wr(0, 8'h09);
        wait_for(0, 1, 100, t);
        @(posedge clk); // status lags the strap latch by one cycle
        #1;
        chk("dly init", 2, 2, dly_o);
        for (i = 0; i < 5; i = i + 1) begin
            k = (i < 4) ? i : 3 + $urandom % 40;
            wr(0, k);
            chk("dly wr", (k < 2) ? 2 : k, (k < 2) ? 2 : k, dly_o);
        end
        wr(1, 0);
        chk("ramp wr", 0, 0, ramp_o);
        // precise 3 ms delay, ramp of 2 ms keeps inrush low
        wr(0, 3);
        wr(1, 2);
        @(posedge clk);
        {precise, slow, en_req} <= 3'h7;
        wait_for(0, 2, 20, t);
        wait_for(0, 3, 60, t);
        chk("delay", 3 * C, 3 * C + 2, t);
        wait_for(0, 4, 40, t);
        chk("ramp len", 2 * C - 2, 2 * C + 3, t);
        chk("vref", vnom, vnom, vref);
        wait_for(1, 1, 40, t);
        chk("pg dly", C - 1, C + 4, t);
        @(posedge clk);
        fault <= 1'b1;
        @(posedge clk);
        #1;
        chk("pg fault", 0, 0, pg);
        @(posedge clk);
        fault <= 1'b0;
        wait_for(1, 1, 40, t);
        chk("pg again", C - 1, C + 4, t);
        // window edges, then widened window
        for (i = 0; i < 6; i = i + 1) begin
            if (i == 4)
                wr(4, 8'h14);
            @(posedge clk);
            ofs <= ov[i][15:0];
            repeat (C + 6) @(posedge clk);
            #1;
            chk("window", (i % 2 == 0), (i % 2 == 0), pg);
        end
        wr(2, 2);
        @(posedge clk);
        ofs <= 16'h0000;
        wait_for(1, 1, 60, t);
        chk("pg dly 2", 2 * C - 1, 2 * C + 4, t);
        // turn off, then zero delay and zero ramp in normal mode
        @(posedge clk);
        en_req <= 1'b0;
        wait_for(0, 1, 20, t);
        chk("off vref", 0, 0, vref);
        wr(0, 0);
        wr(1, 0);
        @(posedge clk);
        {precise, en_req} <= 2'h1;
        vnom <= 200 + $urandom % 3000;
        wait_for(0, 2, 20, t);
        wait_for(0, 3, 40, t);
        chk("zero dly", C - 2, 2 * C + 3, t);
        wait_for(0, 4, 5, t);
        chk("zero ramp", 0, 3, t);
        chk("vref", vnom, vnom, vref);
        report_and_stop;
    end
endmodule

// ---- bench/sspg_checker.sv ----
`timescale 1ns/1ns

module sspg_checker #(
    parameter [31:0] CYC_PER_MS = 32'h0000000a,
    parameter        VW         = 12
) (
    // clock and reset
    input wire          CORE_CLK,
    input wire          NRST,
    // watched inputs
    input wire          RELOAD,
    input wire          FAULT,
    input wire [VW-1:0] VNOM,
    // watched outputs
    input wire [VW-1:0] VREF_OUT,
    input wire          OUTPUT_GOOD_FLAG,
    input wire [7:0]    DLY_MS_OUT,
    input wire [7:0]    RAMP_MS_OUT,
    input wire          READY,
    input wire [2:0]    SEQ_STATE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    reg [31:0] ok_cnt_reg;
    reg [31:0] dly_cnt_reg;
    // cycles on and fault free, cycles in delay
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ok_cnt_reg <= 32'h0;
            dly_cnt_reg <= 32'h0;
        end else begin
            ok_cnt_reg <= (SEQ_STATE == 3'h4 && !FAULT) ? ok_cnt_reg + 32'h1 : 32'h0;
            dly_cnt_reg <= (SEQ_STATE == 3'h2) ? dly_cnt_reg + 32'h1 : 32'h0;
        end
    end
    property p_dly_len;
        SEQ_STATE == 3'h3 && $past(SEQ_STATE) == 3'h2 |-> dly_cnt_reg + CYC_PER_MS >= DLY_MS_OUT * CYC_PER_MS;
    endproperty
    a_dly_len: assert property (p_dly_len) else $error("delay ended early");
    property p_mono;
        SEQ_STATE == 3'h3 && $past(SEQ_STATE) == 3'h3 |-> VREF_OUT >= $past(VREF_OUT);
    endproperty
    a_mono: assert property (p_mono) else $error("ramp stepped back");
    property p_zero;
        SEQ_STATE == 3'h3 && RAMP_MS_OUT == 8'h00 |-> ##[0:2] VREF_OUT == VNOM;
    endproperty
    a_zero: assert property (p_zero) else $error("zero ramp not immediate");
    property p_pg_cond;
        OUTPUT_GOOD_FLAG |-> $past(SEQ_STATE) == 3'h4 && !$past(FAULT);
    endproperty
    a_pg_cond: assert property (p_pg_cond) else $error("flag without conditions");
    property p_pg_drop;
        SEQ_STATE == 3'h4 && FAULT |=> !OUTPUT_GOOD_FLAG;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("flag kept under fault");
    property p_pg_delay;
        $rose(OUTPUT_GOOD_FLAG) |-> ok_cnt_reg >= CYC_PER_MS;
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("flag rose too soon");
    property p_reload;
        RELOAD && SEQ_STATE != 3'h0 |=> SEQ_STATE == 3'h0 && !READY ##1 !OUTPUT_GOOD_FLAG;
    endproperty
    a_reload: assert property (p_reload) else $error("reload not taken");
    property p_init;
        SEQ_STATE == 3'h0 |=> SEQ_STATE == 3'h0 || SEQ_STATE == 3'h1;
    endproperty
    a_init: assert property (p_init) else $error("left init wrongly");
    c_good: cover property ($rose(OUTPUT_GOOD_FLAG));
    c_ramp: cover property (SEQ_STATE == 3'h3);
    c_reload: cover property (RELOAD && SEQ_STATE == 3'h1);
endmodule

bind sspg_top sspg_checker #(.CYC_PER_MS(CYC_PER_MS), .VW(VW)) u_chk (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .RELOAD(RELOAD), .FAULT(FAULT), .VNOM(VNOM),
    .VREF_OUT(VREF_OUT), .OUTPUT_GOOD_FLAG(OUTPUT_GOOD_FLAG), .DLY_MS_OUT(DLY_MS_OUT),
    .RAMP_MS_OUT(RAMP_MS_OUT), .READY(READY), .SEQ_STATE(SEQ_STATE));

// ---- bench/sspg_sys_model.sv ----
`timescale 1ns/1ns

module sspg_sys_model #(
    parameter VW = 12
) (
    // clock
    input  wire          clk,
    // bench commands
    input  wire          en_req,
    input  wire          slow,
    input  wire [15:0]   ofs,
    // block side
    input  wire [VW-1:0] vref,
    output reg           en_pin,
    output reg  [VW-1:0] vout
);
    reg [VW-1:0] lag_reg;
    // turn-on level; output follows reference, one cycle later when slow
    always @(posedge clk) begin
        en_pin <= en_req;
        lag_reg <= vref + ofs[VW-1:0];
        vout <= slow ? lag_reg : vref + ofs[VW-1:0];
    end
endmodule

// ---- core/sspg_map.vh ----
`ifndef SSPG_MAP_VH
`define SSPG_MAP_VH

// time base
`define SSPG_CLK_NS      32'h0000000a
`define SSPG_MS_NS       32'h000f4240

// strap pin levels as delivered by the pin sensing logic
`define SSPG_LVL_LOW     2'h0
`define SSPG_LVL_OPEN    2'h1
`define SSPG_LVL_HIGH    2'h2
`define SSPG_LVL_RES     2'h3

// input undervoltage lockout threshold selections
`define SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_4V5    2'h0
`define SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_5V5    2'h1
`define SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_7V5    2'h2

// time values in milliseconds
`define SSPG_MS_0        8'h00
`define SSPG_MS_2        8'h02
`define SSPG_MS_5        8'h05
`define SSPG_MS_10       8'h0a
`define SSPG_MS_20       8'h14
`define SSPG_MIN_DLY_MS  8'h02
`define SSPG_INIT_MS     8'h05

// resistor code table layout
`define SSPG_RES_CODES   5'h1e
`define SSPG_RES_PER_GRP 5'h03
`define SSPG_GRP_END_4V5 5'h02
`define SSPG_GRP_END_5V5 5'h06

// output good defaults after reset
`define SSPG_PG_DLY_RST  8'h01
`define SSPG_WIN_HI_RST  8'h0f
`define SSPG_WIN_LO_RST  8'h0a
`define SSPG_PCT_FULL    8'h64

`endif

// ---- core/sspg_ramp.v ----
`timescale 1ns/1ns

module sspg_ramp #(
    parameter VW = 12
) (
    // clock and reset
    input  wire          clk,
    input  wire          nrst,
    // control
    input  wire          start,
    input  wire          clear,
    input  wire [VW-1:0] nominal,
    input  wire [31:0]   total,
    // result
    output reg  [VW-1:0] ref_reg,
    output reg           done_reg
);

    reg  [31:0] acc_reg;
    reg  [31:0] elapsed_reg;
    reg         busy_reg;
    wire [32:0] acc_sum;
    wire [31:0] elapsed_inc;

    assign acc_sum     = {1'b0, acc_reg} + {{(33-VW){1'b0}}, nominal};
    assign elapsed_inc = elapsed_reg + 32'h00000001;

    // rate accumulator, at most one lsb up per cycle until the last cycle sets nominal, never down
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_reg     <= {VW{1'b0}};
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            acc_reg     <= 32'h00000000;
            elapsed_reg <= 32'h00000000;
        end else if (clear) begin
            ref_reg     <= {VW{1'b0}};
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
        end else if (start) begin
            acc_reg     <= 32'h00000000;
            elapsed_reg <= 32'h00000000;
            if (total == 32'h00000000) begin
                ref_reg  <= nominal;
                done_reg <= 1'b1;
            end else begin
                ref_reg  <= {VW{1'b0}};
                busy_reg <= 1'b1;
                done_reg <= 1'b0; // no stale completion from an earlier ramp
            end
        end else if (busy_reg) begin
            elapsed_reg <= elapsed_inc;
            if (elapsed_inc >= total) begin
                ref_reg  <= nominal;
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end else if (acc_sum >= {1'b0, total}) begin
                ref_reg <= ref_reg + {{(VW-1){1'b0}}, 1'b1};
                acc_reg <= acc_sum[31:0] - total;
            end else begin
                acc_reg <= acc_sum[31:0];
            end
        end
    end

endmodule

// ---- core/sspg_strap_dec.v ----
`timescale 1ns/1ns
`include "sspg_map.vh"

module sspg_strap_dec (
    // sensed strap
    input  wire [1:0] level,
    input  wire [4:0] code,
    // decoded settings
    output reg  [7:0] dly_ms,
    output reg  [7:0] ramp_ms,
    output reg  [1:0] input_undervoltage_lockout_sel
);

    reg [4:0] grp;
    reg [4:0] pos;

    // three-level and resistor code lookup
    always @* begin
        grp      = code / `SSPG_RES_PER_GRP;
        pos      = code - grp * `SSPG_RES_PER_GRP;
        dly_ms   = `SSPG_MS_5;
        ramp_ms  = `SSPG_MS_5;
        input_undervoltage_lockout_sel = `SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_7V5;
        case (level)
            `SSPG_LVL_LOW: begin
                dly_ms  = `SSPG_MS_2;
                ramp_ms = `SSPG_MS_2;
            end
            `SSPG_LVL_OPEN: begin
                dly_ms  = `SSPG_MS_5;
                ramp_ms = `SSPG_MS_5;
            end
            `SSPG_LVL_HIGH: begin
                dly_ms  = `SSPG_MS_10;
                ramp_ms = `SSPG_MS_10;
            end
            default: begin
                if (code < `SSPG_RES_CODES) begin
                    // delay cycles fastest through 5/10/20
                    case (pos)
                        5'h00:   dly_ms = `SSPG_MS_5;
                        5'h01:   dly_ms = `SSPG_MS_10;
                        default: dly_ms = `SSPG_MS_20;
                    endcase
                    // ramp changes every three codes
                    case (grp)
                        5'h00, 5'h03, 5'h07: ramp_ms = `SSPG_MS_5;
                        5'h01, 5'h04, 5'h08: ramp_ms = `SSPG_MS_10;
                        5'h02, 5'h06:        ramp_ms = `SSPG_MS_2;
                        default:             ramp_ms = `SSPG_MS_20;
                    endcase
                    // threshold by code band
                    if (grp < `SSPG_GRP_END_4V5)
                        input_undervoltage_lockout_sel = `SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_4V5;
                    else if (grp < `SSPG_GRP_END_5V5)
                        input_undervoltage_lockout_sel = `SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_5V5;
                    else
                        input_undervoltage_lockout_sel = `SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_7V5;
                end
            end
        endcase
    end

endmodule

// ---- core/sspg_top.v ----
`timescale 1ns/1ns
`include "sspg_map.vh"

// Operation
// - delay timer starts on turn-on request; the ramp starts only when it expires, and dropping the request returns to idle.
// - after the delay, the target ramps monotonically to nominal over ramp time.
// - three-level strap low/open/high gives 2, 5 or 10 ms delay and ramp.
// - every three-level strap setting selects the 7.5 V lockout threshold.
// - resistor code picks delay 5/10/20 cycling fastest, ramp by groups of three.
// - resistor code band selects lockout threshold 4.5, 5.5 or 7.5 V.
// - strap sampled only at initialisation or reload; later changes ignored.
// - serial writes override delay and ramp times over strap values.
// - zero delay still waits the two millisecond minimum delay.
// - zero ramp time steps the target straight to nominal.
// - precise option bit runs the delay timer with reduced delay variation.
// - output good needs output inside the window and no active fault.
// - window resets to +15/-10 percent; both limits writable.
// - flag asserts only after conditions hold for the whole good delay.
// - output good delay resets to 1 ms and is writable.
// - turn-on delays below 2 ms become 2 ms; longer ones are honoured.
// - during the memory check turn-on request and bus writes are ignored.
module sspg_top #(
    parameter [31:0] CYC_PER_MS = `SSPG_MS_NS / `SSPG_CLK_NS,
    parameter        VW         = 12
) (
    // clock and reset
    input  wire          CORE_CLK,
    input  wire          NRST,
    // turn-on request pin
    input  wire          EN_PIN,
    // strap sensing
    input  wire [1:0]    STRAP_LEVEL,
    input  wire [4:0]    STRAP_CODE,
    // serial interface commands and writes
    input  wire          RELOAD,
    input  wire          DLY_WR,
    input  wire [7:0]    DLY_DATA,
    input  wire          RAMP_WR,
    input  wire [7:0]    RAMP_DATA,
    input  wire          PG_DLY_WR,
    input  wire [7:0]    PG_DLY_DATA,
    input  wire          WIN_WR,
    input  wire [7:0]    WIN_HI_DATA,
    input  wire [7:0]    WIN_LO_DATA,
    input  wire          PRECISE_EN,
    // regulation loop
    input  wire [VW-1:0] VNOM,
    input  wire [VW-1:0] VOUT_MEAS,
    input  wire          FAULT,
    // outputs
    output wire [VW-1:0] VREF_OUT,
    output reg           OUTPUT_GOOD_FLAG,
    output reg  [1:0]    INPUT_UNDERVOLTAGE_LOCKOUT_SEL,
    output reg  [7:0]    DLY_MS_OUT,
    output reg  [7:0]    RAMP_MS_OUT,
    output reg           READY,
    output reg  [2:0]    SEQ_STATE
);

    localparam [2:0] ST_INIT  = 3'h0;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_RAMP  = 3'h3;
    localparam [2:0] ST_ON    = 3'h4;
    localparam       MW       = VW + 10;

    // pin synchroniser and filtered level
    reg          en_s1_reg;
    reg          en_s2_reg;
    reg          en_s3_reg;
    reg          en_reg;
    // millisecond time base
    reg  [31:0]  pre_reg;
    wire         ms_tick;
    wire         pre_restart;
    // sequencer
    reg  [2:0]   state_reg;
    reg  [2:0]   state_next;
    reg  [7:0]   cnt_reg;
    reg  [7:0]   cnt_next;
    reg          ramp_go;
    reg          ramp_clr;
    reg          latch_strap;
    // configuration
    reg  [7:0]   strap_dly_reg;
    reg  [7:0]   strap_ramp_reg;
    reg  [7:0]   ovr_dly_reg;
    reg  [7:0]   ovr_ramp_reg;
    reg          ovr_dly_vld_reg;
    reg          ovr_ramp_vld_reg;
    reg  [7:0]   pg_dly_reg;
    reg  [7:0]   win_hi_reg;
    reg  [7:0]   win_lo_reg;
    wire [7:0]   dec_dly;
    wire [7:0]   dec_ramp;
    wire [1:0]   dec_input_undervoltage_lockout;
    wire [7:0]   cfg_dly;
    wire [7:0]   eff_dly;
    wire [7:0]   eff_ramp;
    wire [31:0]  ramp_tot;
    wire         bus_open;
    wire         ramp_done;
    // output good
    reg  [31:0]  pg_cnt_reg;
    wire [31:0]  pg_tot;
    wire [8:0]   hi_pct;
    wire [7:0]   lo_pct;
    wire [MW-1:0] meas_sc;
    wire [MW-1:0] hi_lim;
    wire [MW-1:0] lo_lim;
    wire         in_window;
    wire         pg_cond;

    // three flops; a change counts once second and third agree
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            en_s3_reg <= 1'b0;
            en_reg    <= 1'b0;
        end else begin
            en_s1_reg <= EN_PIN;
            en_s2_reg <= en_s1_reg;
            en_s3_reg <= en_s2_reg;
            if (en_s2_reg == en_s3_reg)
                en_reg <= en_s3_reg;
        end
    end

    // free running prescaler; precise mode realigns it at turn-on
    assign pre_restart = PRECISE_EN && (state_reg == ST_IDLE) && en_reg;
    assign ms_tick     = (pre_reg == CYC_PER_MS - 32'h00000001);

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST)
            pre_reg <= 32'h00000000;
        else if (pre_restart || ms_tick)
            pre_reg <= 32'h00000000;
        else
            pre_reg <= pre_reg + 32'h00000001;
    end

    // strap decoder
    sspg_strap_dec u_dec (
        .level    (STRAP_LEVEL),
        .code     (STRAP_CODE),
        .dly_ms   (dec_dly),
        .ramp_ms  (dec_ramp),
        .input_undervoltage_lockout_sel (dec_input_undervoltage_lockout)
    );

    // effective delay and ramp selection
    assign cfg_dly  = ovr_dly_vld_reg ? ovr_dly_reg : strap_dly_reg;
    assign eff_dly  = (cfg_dly < `SSPG_MIN_DLY_MS) ? `SSPG_MIN_DLY_MS : cfg_dly;
    assign eff_ramp = ovr_ramp_vld_reg ? ovr_ramp_reg : strap_ramp_reg;
    assign ramp_tot = {24'h000000, eff_ramp} * CYC_PER_MS;
    assign bus_open = (state_reg != ST_INIT);

    // sequencer next state
    always @* begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        ramp_go     = 1'b0;
        ramp_clr    = 1'b0;
        latch_strap = 1'b0;
        case (state_reg)
            ST_INIT: begin
                // request ignored while the memory check runs
                if (cnt_reg == `SSPG_INIT_MS) begin
                    latch_strap = 1'b1;
                    cnt_next    = `SSPG_MS_0;
                    state_next  = ST_IDLE;
                end else if (ms_tick) begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            ST_IDLE: begin
                if (en_reg) begin
                    cnt_next   = `SSPG_MS_0;
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!en_reg) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg == eff_dly) begin
                    ramp_go    = 1'b1;
                    state_next = ST_RAMP;
                end else if (ms_tick) begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            ST_RAMP: begin
                if (!en_reg) begin
                    ramp_clr   = 1'b1;
                    state_next = ST_IDLE;
                end else if (ramp_done) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (!en_reg) begin
                    ramp_clr   = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                ramp_clr   = 1'b1;
                cnt_next   = `SSPG_MS_0;
                state_next = ST_INIT;
            end
        endcase
        // reload reruns the memory check and strap sampling
        if (RELOAD && bus_open) begin
            ramp_clr   = 1'b1;
            cnt_next   = `SSPG_MS_0;
            state_next = ST_INIT;
        end
    end

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_INIT;
            cnt_reg   <= `SSPG_MS_0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // strap latch, taken only at the end of initialisation
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            strap_dly_reg  <= `SSPG_MS_5;
            strap_ramp_reg <= `SSPG_MS_5;
            INPUT_UNDERVOLTAGE_LOCKOUT_SEL       <= `SSPG_INPUT_UNDERVOLTAGE_LOCKOUT_7V5;
        end else if (latch_strap) begin
            strap_dly_reg  <= dec_dly;
            strap_ramp_reg <= dec_ramp;
            INPUT_UNDERVOLTAGE_LOCKOUT_SEL       <= dec_input_undervoltage_lockout;
        end
    end

    // serial overrides and output good settings
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ovr_dly_reg      <= `SSPG_MS_0;
            ovr_ramp_reg     <= `SSPG_MS_0;
            ovr_dly_vld_reg  <= 1'b0;
            ovr_ramp_vld_reg <= 1'b0;
            pg_dly_reg       <= `SSPG_PG_DLY_RST;
            win_hi_reg       <= `SSPG_WIN_HI_RST;
            win_lo_reg       <= `SSPG_WIN_LO_RST;
        end else if (bus_open) begin
            if (RELOAD) begin
                ovr_dly_vld_reg  <= 1'b0;
                ovr_ramp_vld_reg <= 1'b0;
            end else begin
                if (DLY_WR) begin
                    ovr_dly_reg     <= DLY_DATA;
                    ovr_dly_vld_reg <= 1'b1;
                end
                if (RAMP_WR) begin
                    ovr_ramp_reg     <= RAMP_DATA;
                    ovr_ramp_vld_reg <= 1'b1;
                end
                if (PG_DLY_WR)
                    pg_dly_reg <= PG_DLY_DATA;
                if (WIN_WR) begin
                    win_hi_reg <= WIN_HI_DATA;
                    win_lo_reg <= WIN_LO_DATA;
                end
            end
        end
    end

    // reference ramp generator
    sspg_ramp #(
        .VW (VW)
    ) u_ramp (
        .clk      (CORE_CLK),
        .nrst     (NRST),
        .start    (ramp_go),
        .clear    (ramp_clr),
        .nominal  (VNOM),
        .total    (ramp_tot),
        .ref_reg  (VREF_OUT),
        .done_reg (ramp_done)
    );

    // tolerance window, compared in percent without division
    assign hi_pct    = {1'b0, `SSPG_PCT_FULL} + {1'b0, win_hi_reg};
    assign lo_pct    = (win_lo_reg >= `SSPG_PCT_FULL) ? 8'h00 :
                       (`SSPG_PCT_FULL - win_lo_reg);
    assign meas_sc   = {{(MW-VW){1'b0}}, VOUT_MEAS} * {{(MW-8){1'b0}}, `SSPG_PCT_FULL};
    assign hi_lim    = {{(MW-VW){1'b0}}, VNOM} * {{(MW-9){1'b0}}, hi_pct};
    assign lo_lim    = {{(MW-VW){1'b0}}, VNOM} * {{(MW-8){1'b0}}, lo_pct};
    assign in_window = (meas_sc <= hi_lim) && (meas_sc >= lo_lim);
    assign pg_cond   = (state_reg == ST_ON) && in_window && !FAULT;
    assign pg_tot    = {24'h000000, pg_dly_reg} * CYC_PER_MS;

    // good flag after a full uninterrupted delay
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pg_cnt_reg       <= 32'h00000000;
            OUTPUT_GOOD_FLAG <= 1'b0;
        end else if (!pg_cond) begin
            pg_cnt_reg       <= 32'h00000000;
            OUTPUT_GOOD_FLAG <= 1'b0;
        end else if (pg_cnt_reg >= pg_tot) begin
            OUTPUT_GOOD_FLAG <= 1'b1;
        end else begin
            pg_cnt_reg <= pg_cnt_reg + 32'h00000001;
        end
    end

    // status outputs
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            DLY_MS_OUT  <= `SSPG_MS_0;
            RAMP_MS_OUT <= `SSPG_MS_0;
            READY       <= 1'b0;
            SEQ_STATE   <= ST_INIT;
        end else begin
            DLY_MS_OUT  <= eff_dly;
            RAMP_MS_OUT <= eff_ramp;
            READY       <= (state_next != ST_INIT);
            SEQ_STATE   <= state_next;
        end
    end

endmodule
